// >>> common/tsm_pkg.sv
// Constants shared by the timer slave-mode trigger controller.
// Assumes a 32-bit AHB-Lite register bus and one timer kernel clock.
package tsm_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] TSM_SMCTRL_OFF = 8'h08;
    localparam logic [7:0] TSM_STATUS_OFF = 8'h20;
    localparam logic [15:0] TSM_SMCTRL_RST = 16'h0000;
    localparam logic [15:0] TSM_SMCTRL_WMASK = 16'hFFF7;
    // ------------------------------------------------------------
    // Field positions of slave_mode_control
    // ------------------------------------------------------------
    localparam int TSM_SMF_LSB = 0;
    localparam int TSM_TRG_LSB = 4;
    localparam int TSM_MSM_BIT = 7;
    localparam int TSM_ETF_LSB = 8;
    localparam int TSM_ETP_LSB = 12;
    localparam int TSM_EXT2_BIT = 14;
    localparam int TSM_INV_BIT = 15;
    // ------------------------------------------------------------
    // Status register bit positions
    // ------------------------------------------------------------
    localparam int TSM_ST_TRG = 0;
    localparam int TSM_ST_XFILT = 1;
    localparam int TSM_ST_DOWN = 2;
    localparam int TSM_ST_XPRESC = 3;
    // ------------------------------------------------------------
    // Slave functions
    // ------------------------------------------------------------
    localparam logic [2:0] TSM_SMF_OFF = 3'h0;
    localparam logic [2:0] TSM_SMF_ENC1 = 3'h1;
    localparam logic [2:0] TSM_SMF_ENC2 = 3'h2;
    localparam logic [2:0] TSM_SMF_ENC3 = 3'h3;
    localparam logic [2:0] TSM_SMF_RESET = 3'h4;
    localparam logic [2:0] TSM_SMF_GATED = 3'h5;
    localparam logic [2:0] TSM_SMF_TRIG = 3'h6;
    localparam logic [2:0] TSM_SMF_EXTCLK = 3'h7;
    // ------------------------------------------------------------
    // Trigger sources
    // ------------------------------------------------------------
    localparam logic [2:0] TSM_TRG_CH1ED = 3'h4;
    localparam logic [2:0] TSM_TRG_CH1 = 3'h5;
    localparam logic [2:0] TSM_TRG_CH2 = 3'h6;
    localparam logic [2:0] TSM_TRG_XFILT = 3'h7;
    // ------------------------------------------------------------
    // AHB encodings
    // ------------------------------------------------------------
    localparam logic [1:0] TSM_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] TSM_HSIZE_WORD = 3'h2;
endpackage

// >>> hdl/tsm_etr_filter.sv
// External trigger digital filter: sample divider plus agreement counter.
// Assumes its input is already synchronised to hclk.
`timescale 1ns/1ps
`default_nettype none
module tsm_xtrig_filter
    import tsm_pkg::*;
#(
    parameter int DIV_W = 5
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [3:0] cfg,
    input wire logic din,
    output logic dout
);
    // Sampling divider minus one for each code
    function automatic logic [DIV_W-1:0] div_m1(input logic [3:0] c);
        case (c)
            4'h0, 4'h1, 4'h2, 4'h3: div_m1 = DIV_W'(0);
            4'h4, 4'h5: div_m1 = DIV_W'(1);
            4'h6, 4'h7: div_m1 = DIV_W'(3);
            4'h8, 4'h9: div_m1 = DIV_W'(7);
            4'hA, 4'hB, 4'hC: div_m1 = DIV_W'(15);
            default: div_m1 = DIV_W'(31);
        endcase
    endfunction

    // Samples that must agree before the output moves
    function automatic logic [3:0] flen(input logic [3:0] c);
        case (c)
            4'h1: flen = 4'h2;
            4'h2: flen = 4'h4;
            4'h4, 4'h6, 4'h8, 4'hB, 4'hE: flen = 4'h6;
            4'hA, 4'hD: flen = 4'h5;
            4'h0: flen = 4'h1;
            default: flen = 4'h8;
        endcase
    endfunction

    logic [DIV_W-1:0] dcnt_r;
    logic [3:0] agree_r;
    logic samp_en;

    assign samp_en = (dcnt_r >= div_m1(cfg));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dcnt_r <= '0;
        end else if (samp_en) begin
            dcnt_r <= '0;
        end else begin
            dcnt_r <= dcnt_r + DIV_W'(1);
        end
    end

    // code zero passes each sample; N agreeing samples flip the output
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            agree_r <= '0;
            dout <= 1'b0;
        end else if (samp_en) begin
            if (din == dout) begin
                agree_r <= '0;
            end else if (agree_r + 4'h1 >= flen(cfg)) begin
                agree_r <= '0;
                dout <= din;
            end else begin
                agree_r <= agree_r + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> hdl/tsm_slave_ctrl.sv
// Timer slave-mode and trigger-input controller with its AHB-Lite register.
// Assumes the counter core, channels and peer timers share hclk; only the
// external trigger pin is asynchronous.
`timescale 1ns/1ps
`default_nettype none
module tsm_slave_ctrl
    import tsm_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic counter_run_enable,
    input wire logic ch1_filtered_input,
    input wire logic ch2_filtered_input,
    input wire logic ch1_edge_detect,
    input wire logic [3:0] internal_trigger,
    input wire logic ext_trigger_pin,
    output logic cnt_step_r,
    output logic cnt_down_r,
    output logic cnt_reinit_r,
    output logic update_evt_r,
    output logic run_start_r,
    output logic trig_event_r,
    output logic master_slave_sync_enable
);
    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic [15:0] smctrl_r;
    logic wr_pend_r;
    logic [ADDR_W-1:0] wr_addr_r;
    logic addr_ok;
    logic [3:0] status;
    logic [31:0] rd_nxt;
    logic [15:0] wr_val;

    assign addr_ok = hsel && hready && (htrans == TSM_HTRANS_NONSEQ);
    assign wr_val = hwdata[15:0] & TSM_SMCTRL_WMASK;

    // Write data phase follows the captured address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= '0;
        end else begin
            wr_pend_r <= addr_ok && hwrite;
            wr_addr_r <= haddr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            smctrl_r <= TSM_SMCTRL_RST;
        end else if (wr_pend_r && wr_addr_r == ADDR_W'(TSM_SMCTRL_OFF)) begin
            smctrl_r <= wr_val;
        end
    end

    // Read data is formed in the address phase; a write still in its data
    // phase to the same word is forwarded so back-to-back reads see it
    always_comb begin
        rd_nxt = '0;
        if (haddr == ADDR_W'(TSM_SMCTRL_OFF)) begin
            if (wr_pend_r && wr_addr_r == ADDR_W'(TSM_SMCTRL_OFF)) begin
                rd_nxt[15:0] = wr_val;
            end else begin
                rd_nxt[15:0] = smctrl_r;
            end
        end else if (haddr == ADDR_W'(TSM_STATUS_OFF)) begin
            rd_nxt[3:0] = status;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (addr_ok && !hwrite) begin
            hrdata <= rd_nxt;
        end
    end

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    logic [2:0] smf;
    logic [2:0] trg_sel;
    logic [3:0] etf_cfg;
    logic [1:0] etp_cfg;

    assign smf = smctrl_r[TSM_SMF_LSB +: 3];
    assign trg_sel = smctrl_r[TSM_TRG_LSB +: 3];
    assign etf_cfg = smctrl_r[TSM_ETF_LSB +: 4];
    assign etp_cfg = smctrl_r[TSM_ETP_LSB +: 2];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            master_slave_sync_enable <= 1'b0;
        end else begin
            master_slave_sync_enable <= smctrl_r[TSM_MSM_BIT];
        end
    end

    // ------------------------------------------------------------
    // External trigger path
    // ------------------------------------------------------------
    logic xtrig_s1_r;
    logic xtrig_s2_r;
    logic xtrig_d_r;
    logic [2:0] xtrig_div_r;
    logic xtrig_presc_r;
    logic xtrig_filt;

    // Pin synchroniser
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            xtrig_s1_r <= 1'b0;
            xtrig_s2_r <= 1'b0;
        end else begin
            xtrig_s1_r <= ext_trigger_pin;
            xtrig_s2_r <= xtrig_s1_r;
        end
    end

    // polarity; divide by counting rising edges
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            xtrig_d_r <= 1'b0;
            xtrig_div_r <= '0;
            xtrig_presc_r <= 1'b0;
        end else begin
            xtrig_d_r <= xtrig_s2_r ^ smctrl_r[TSM_INV_BIT];
            if ((xtrig_s2_r ^ smctrl_r[TSM_INV_BIT]) && !xtrig_d_r) begin
                xtrig_div_r <= xtrig_div_r + 3'h1;
            end
            case (etp_cfg)
                2'h0: xtrig_presc_r <= xtrig_s2_r ^ smctrl_r[TSM_INV_BIT];
                2'h1: xtrig_presc_r <= xtrig_div_r[0];
                2'h2: xtrig_presc_r <= xtrig_div_r[1];
                default: xtrig_presc_r <= xtrig_div_r[2];
            endcase
        end
    end

    tsm_xtrig_filter u_filt (
        .hclk(hclk),
        .hresetn(hresetn),
        .cfg(etf_cfg),
        .din(xtrig_presc_r),
        .dout(xtrig_filt)
    );

    // ------------------------------------------------------------
    // Trigger selection and edge detection
    // ------------------------------------------------------------
    logic trg_mux;
    logic trg_r;
    logic trg_d_r;
    logic trg_rise;
    logic xtrig_filt_d_r;
    logic xtrig_filt_rise;

    always_comb begin
        case (trg_sel)
            TSM_TRG_CH1ED: trg_mux = ch1_edge_detect;
            TSM_TRG_CH1: trg_mux = ch1_filtered_input;
            TSM_TRG_CH2: trg_mux = ch2_filtered_input;
            TSM_TRG_XFILT: trg_mux = xtrig_filt;
            default: trg_mux = internal_trigger[trg_sel[1:0]];
        endcase
    end

    // retime then detect edges; a source change relies on function 000
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trg_r <= 1'b0;
            trg_d_r <= 1'b0;
            xtrig_filt_d_r <= 1'b0;
        end else begin
            trg_r <= trg_mux;
            trg_d_r <= trg_r;
            xtrig_filt_d_r <= xtrig_filt;
        end
    end

    assign trg_rise = trg_r && !trg_d_r;
    assign xtrig_filt_rise = xtrig_filt && !xtrig_filt_d_r;

    // ------------------------------------------------------------
    // Quadrature decode
    // ------------------------------------------------------------
    logic ch1_d_r;
    logic ch2_d_r;
    logic ch1_edge;
    logic ch2_edge;
    logic enc_step;
    logic enc_down;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ch1_d_r <= 1'b0;
            ch2_d_r <= 1'b0;
        end else begin
            ch1_d_r <= ch1_filtered_input;
            ch2_d_r <= ch2_filtered_input;
        end
    end

    assign ch1_edge = ch1_filtered_input ^ ch1_d_r;
    assign ch2_edge = ch2_filtered_input ^ ch2_d_r;

    // channel 1 leading channel 2 counts up
    always_comb begin
        enc_step = 1'b0;
        enc_down = cnt_down_r;
        if ((smf == TSM_SMF_ENC2 || smf == TSM_SMF_ENC3) && ch1_edge) begin
            enc_step = 1'b1;
            enc_down = (ch1_filtered_input == ch2_filtered_input);
        end
        if ((smf == TSM_SMF_ENC1 || smf == TSM_SMF_ENC3) && ch2_edge) begin
            enc_step = 1'b1;
            enc_down = (ch2_filtered_input != ch1_filtered_input);
        end
    end

    // ------------------------------------------------------------
    // Slave function
    // ------------------------------------------------------------
    logic int_tick;

    // External clock mode 2 replaces the internal tick by filtered trigger edges
    assign int_tick = smctrl_r[TSM_EXT2_BIT] ? xtrig_filt_rise : 1'b1;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_step_r <= 1'b0;
            cnt_down_r <= 1'b0;
        end else begin
            cnt_down_r <= enc_down;
            case (smf)
                TSM_SMF_ENC1, TSM_SMF_ENC2, TSM_SMF_ENC3: begin
                    cnt_step_r <= counter_run_enable && enc_step;
                end
                TSM_SMF_GATED: begin
                    cnt_step_r <= counter_run_enable && int_tick && trg_r;
                end
                TSM_SMF_EXTCLK: begin
                    cnt_step_r <= counter_run_enable && trg_rise;
                end
                default: begin
                    cnt_step_r <= counter_run_enable && int_tick;
                end
            endcase
        end
    end

    // reset mode and trigger mode events, plus the trigger event of every function but 000
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_reinit_r <= 1'b0;
            update_evt_r <= 1'b0;
            run_start_r <= 1'b0;
            trig_event_r <= 1'b0;
        end else begin
            cnt_reinit_r <= (smf == TSM_SMF_RESET) && trg_rise;
            update_evt_r <= (smf == TSM_SMF_RESET) && trg_rise;
            run_start_r <= (smf == TSM_SMF_TRIG) && trg_rise;
            trig_event_r <= (smf != TSM_SMF_OFF) && trg_rise;
        end
    end

    assign status = {xtrig_presc_r, cnt_down_r, xtrig_filt, trg_r};

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence trg_edge_s;
        trg_r && !trg_d_r;
    endsequence

    reset_event_a: assert property ((smf == TSM_SMF_RESET) ##0 trg_edge_s |=>
        cnt_reinit_r && update_evt_r) else $error("reset mode edge lost");
    trig_start_a: assert property (run_start_r |-> $past(smf) == TSM_SMF_TRIG
        && $past(trg_rise)) else $error("run start without trigger edge");
    gate_hold_a: assert property (($past(smf) == TSM_SMF_GATED && !$past(trg_r))
        |-> !cnt_step_r && !cnt_reinit_r) else $error("gated counter moved");
    extclk_step_a: assert property ((smf == TSM_SMF_EXTCLK && counter_run_enable
        && !trg_rise) |=> !cnt_step_r) else $error("step without trigger edge");
    off_step_a: assert property ((smf == TSM_SMF_OFF && !smctrl_r[TSM_EXT2_BIT])
        |=> cnt_step_r == $past(counter_run_enable)) else $error("internal tick wrong");
    quad_up_a: assert property ((smf == TSM_SMF_ENC3 && counter_run_enable
        && $rose(ch1_filtered_input) && !ch2_filtered_input && !ch2_edge)
        |=> cnt_step_r && !cnt_down_r) else $error("quadrature direction wrong");
    ctl_reset_a: assert property ($rose(hresetn) |-> smctrl_r == TSM_SMCTRL_RST)
        else $error("control not cleared");
    trg_retime_a: assert property (trg_rise |-> $past(trg_mux, 1) && !$past(trg_mux, 2))
        else $error("edge not from retimed source");
    etp_bypass_a: assert property ((etp_cfg == 2'h0) ##1 (etp_cfg == 2'h0)
        |-> xtrig_presc_r == $past(xtrig_s2_r ^ smctrl_r[TSM_INV_BIT]))
        else $error("bypass wrong");
    msm_out_a: assert property (master_slave_sync_enable == $past(smctrl_r[TSM_MSM_BIT]))
        else $error("sync enable mismatch");
endmodule
`default_nettype wire

// >>> sim/tsm_enc_model.sv
// Behavioural far side: a quadrature encoder and its channel 1 edge detector.
// Assumes one request per step, sampled on hclk, spaced by the bench.
`timescale 1ns/1ps
`default_nettype none
module tsm_enc_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic step_req,
    input wire logic step_rev,
    output logic ch1,
    output logic ch2,
    output logic ch1_edge
);
    logic [1:0] phase_r;
    logic ch1_prev_r;

    // ----
    // Shaft position
    // ----
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_r <= 2'h0;
        end else if (step_req) begin
            phase_r <= step_rev ? phase_r - 2'h1 : phase_r + 2'h1;
        end
    end

    assign ch1 = phase_r[1] ^ phase_r[0];
    assign ch2 = phase_r[1];

    // Edge detector pulses one cycle on either ch1 transition
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ch1_prev_r <= 1'b0;
        end else begin
            ch1_prev_r <= ch1;
        end
    end
    assign ch1_edge = ch1 ^ ch1_prev_r;
endmodule
`default_nettype wire

// >>> sim/tsm_slave_ctrl_tb.sv
// Self-checking bench for the slave-mode trigger controller.
// Assumes tsm_pkg, the design and the encoder model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin err_total++; \
    $display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end
module tsm_slave_ctrl_tb import tsm_pkg::*;;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic cre = 1'b1;
    logic [3:0] itrig = 4'h0;
    logic pin = 1'b0;
    logic step_req = 1'b0;
    logic step_rev = 1'b0;
    logic ch1, ch2, ch1_ed, cnt_down, msm;
    logic [4:0] pulses;
    int err_total = 0;
    int checks_done = 0;
    int cycles = 0;
    int pc[5];
    int pb[5];

    always #10 hclk = ~hclk;

    tsm_slave_ctrl dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(TSM_HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .counter_run_enable(cre), .ch1_filtered_input(ch1), .ch2_filtered_input(ch2),
        .ch1_edge_detect(ch1_ed), .internal_trigger(itrig), .ext_trigger_pin(pin),
        .cnt_step_r(pulses[0]), .cnt_down_r(cnt_down), .cnt_reinit_r(pulses[1]),
        .update_evt_r(pulses[2]), .run_start_r(pulses[3]), .trig_event_r(pulses[4]),
        .master_slave_sync_enable(msm)
    );

    tsm_enc_model far_enc (
        .hclk(hclk), .hresetn(hresetn), .step_req(step_req), .step_rev(step_rev),
        .ch1(ch1), .ch2(ch2), .ch1_edge(ch1_ed)
    );

    // ----
    // Pulse counters, sampled mid-cycle to stay clear of the edge
    // ----
    always @(negedge hclk) begin
        for (int i = 0; i < 5; i++) begin
            if (pulses[i] === 1'b1) begin
                pc[i]++;
            end
        end
    end

    always @(posedge hclk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            finish_test();
        end
    end

    // ----
    // Shared tasks
    // ----
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask

    function automatic int dlt(input int i);
        return pc[i] - pb[i];
    endfunction

    task automatic done(input string nm);
        $display("test %s finished", nm);
    endtask

    task automatic ahb_xfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
                            output logic [31:0] rd);
        haddr <= a;
        hwrite <= w;
        htrans <= TSM_HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        `CHK("hresp", 1'b0, hresp)
    endtask

    // Source and options go in with the slave function off, then the function
    task automatic cfg(input logic [2:0] fn, input logic [2:0] src, input logic [15:0] ext);
        logic [31:0] rd;
        // function off first, old source kept, then the new source
        ahb_xfer(TSM_SMCTRL_OFF, 1'b0, 32'h0, rd);
        ahb_xfer(TSM_SMCTRL_OFF, 1'b1, rd & 32'h0000_FFF8, rd);
        ahb_xfer(TSM_SMCTRL_OFF, 1'b1, {16'h0, ext | {9'h0, src, 4'h0}}, rd);
        cyc(6);
        ahb_xfer(TSM_SMCTRL_OFF, 1'b1, {16'h0, ext | {9'h0, src, 1'b0, fn}}, rd);
        cyc(3);
        pb = pc;
    endtask

    task automatic enc(input logic rev);
        step_rev <= rev;
        step_req <= 1'b1;
        cyc(1);
        step_req <= 1'b0;
        cyc(4);
    endtask

    // Unselected internal triggers fire first and must be ignored
    task automatic fire(input int s);
        if (s < 4) begin
            itrig <= 4'hF ^ (4'h1 << s);
            cyc(4);
            itrig <= 4'h0;
            cyc(4);
            itrig <= 4'h1 << s;
            cyc(4);
            itrig <= 4'h0;
        end else if (s == 7) begin
            pin <= 1'b1;
            cyc(8);
            pin <= 1'b0;
        end else begin
            repeat (4) enc(1'b0);
        end
        cyc(12);
    endtask

    task automatic glitch();
        pin <= 1'b1;
        cyc(1);
        pin <= 1'b0;
        cyc(12);
    endtask

    // ----
    // Scenarios
    // ----
    task automatic t_regs();
        logic [31:0] rd;
        ahb_xfer(TSM_SMCTRL_OFF, 1'b0, 32'h0, rd);
        `CHK("ctrl reset", {16'h0, TSM_SMCTRL_RST}, rd)
        ahb_xfer(TSM_SMCTRL_OFF, 1'b1, 32'hFFFF_FF88, rd);
        ahb_xfer(TSM_SMCTRL_OFF, 1'b0, 32'h0, rd);
        `CHK("ctrl rw", {16'h0, 16'hFF88 & TSM_SMCTRL_WMASK}, rd)
        `CHK("sync on", 1'b1, msm)
        ahb_xfer(8'h04, 1'b1, 32'hFFFF_FFFF, rd);
        ahb_xfer(8'h04, 1'b0, 32'h0, rd);
        `CHK("unmapped", 32'h0, rd)
        ahb_xfer(TSM_SMCTRL_OFF, 1'b1, 32'h0, rd);
        cyc(2);
        `CHK("sync off", 1'b0, msm)
        done("regs");
    endtask

    task automatic t_free();
        cfg(TSM_SMF_OFF, 3'h0, 16'h0);
        cyc(10);
        `CHK("free steps", 10, dlt(0))
        cre <= 1'b0;
        cyc(3);
        pb = pc;
        cyc(8);
        `CHK("held steps", 0, dlt(0))
        cre <= 1'b1;
        done("free");
    endtask

    task automatic t_src();
        for (int s = 0; s < 8; s++) begin
            cfg(TSM_SMF_RESET, 3'(s), 16'h0);
            fire(s);
            `CHK("reinit", (s == 4) ? 2 : 1, dlt(1))
            `CHK("update", (s == 4) ? 2 : 1, dlt(2))
            `CHK("trig event", (s == 4) ? 2 : 1, dlt(4))
        end
        done("sources");
    endtask

    task automatic t_modes();
        cfg(TSM_SMF_TRIG, 3'h1, 16'h0);
        fire(1);
        `CHK("start", 1, dlt(3))
        `CHK("no reinit", 0, dlt(1))
        cfg(TSM_SMF_GATED, 3'h2, 16'h0);
        repeat (2) begin
            itrig <= 4'h4;
            cyc(5);
            itrig <= 4'h0;
            cyc(5);
        end
        `CHK("gated steps", 10, dlt(0))
        `CHK("gated clear", 0, dlt(1))
        cfg(TSM_SMF_EXTCLK, 3'h3, 16'h0);
        repeat (3) begin
            itrig <= 4'h8;
            cyc(2);
            itrig <= 4'h0;
            cyc(2);
        end
        cyc(4);
        `CHK("ext clk steps", 3, dlt(0))
        done("modes");
    endtask

    task automatic t_enc();
        int ex;
        logic [31:0] rd;
        for (int m = 1; m < 4; m++) begin
            ex = (m == 3) ? 4 : 2;
            cfg(3'(m), 3'h0, 16'h0);
            repeat (4) enc(1'b0);
            `CHK("enc up steps", ex, dlt(0))
            `CHK("enc up dir", 1'b0, cnt_down)
            pb = pc;
            repeat (4) enc(1'b1);
            `CHK("enc down steps", ex, dlt(0))
            `CHK("enc down dir", 1'b1, cnt_down)
        end
        ahb_xfer(TSM_STATUS_OFF, 1'b0, 32'h0, rd);
        `CHK("status dir", 32'h1 << TSM_ST_DOWN, rd)
        done("encoder");
    endtask

    task automatic t_presc();
        for (int p = 0; p < 4; p++) begin
            cfg(TSM_SMF_EXTCLK, TSM_TRG_XFILT, 16'(p) << 12);
            // pin kept at an eighth of the clock
            repeat (8) begin
                pin <= 1'b1;
                cyc(4);
                pin <= 1'b0;
                cyc(4);
            end
            cyc(10);
            `CHK("prescaled steps", 8 >> p, dlt(0))
        end
        done("prescaler");
    endtask

    task automatic t_filt();
        cfg(TSM_SMF_RESET, TSM_TRG_XFILT, 16'h0100);
        glitch();
        `CHK("glitch blocked", 0, dlt(1))
        fire(7);
        `CHK("long pulse", 1, dlt(1))
        cfg(TSM_SMF_RESET, TSM_TRG_XFILT, 16'h0000);
        glitch();
        `CHK("unfiltered glitch", 1, dlt(1))
        cfg(TSM_SMF_RESET, TSM_TRG_XFILT, 16'h8000);
        fire(7);
        `CHK("inverted edge", 1, dlt(1))
        done("filter");
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        cyc(2);
        hresetn <= 1'b1;
        cyc(1);
        t_regs();
        t_free();
        t_src();
        t_modes();
        t_enc();
        t_presc();
        t_filt();
        finish_test();
    end
endmodule
`default_nettype wire
